// *** rtl/pinctl_defines.svh ***
// Register map, field positions, reset values and thresholds of the channel pin-state block.
`ifndef PINCTL_DEFINES_SVH
`define PINCTL_DEFINES_SVH

// ************************************************************
// Register byte offsets
// ************************************************************
`define CTRL_OFFSET 8'h00
`define STATUS_OFFSET 8'h04
`define MASK_OFFSET 8'h08
`define STATE_OFFSET 8'h0c

// ************************************************************
// Control register fields
// ************************************************************
`define CTRL_MODE_LSB 0
`define CTRL_SEL_LSB 2
`define CTRL_LOS_EN_BIT 4
`define CTRL_DP_RESET_BIT 8
`define CTRL_POWERDOWN_BIT 15

// ************************************************************
// Event bits, shared by status and mask
// ************************************************************
`define EVT_LOS_RISE 0
`define EVT_LOS_FALL 1
`define EVT_PD_RELEASE 2
`define EVT_W 3

// ************************************************************
// State register fields
// ************************************************************
`define STATE_LOS_BIT 0
`define STATE_PD_BIT 1
`define STATE_WAIT_BIT 2
`define STATE_MODE_LSB 4

// ************************************************************
// Reset values
// ************************************************************
`define MODE_RESET 2'h0
`define SEL_RESET 2'h0
`define LOS_EN_RESET 1'h1
`define REG_PD_RESET 1'h0
`define MASK_RESET 3'h0

// ************************************************************
// Swing thresholds in mVpp: assert below 75, release above 150
// ************************************************************
`define SWING_W 9
`define LOS_ASSERT_MVPP 9'h04b
`define LOS_RELEASE_MVPP 9'h096

`endif

// *** rtl/pinctl_pkg.sv ***
// Types shared by the channel pin-state block and its helpers.
package pinctl_pkg;

  // Serialization ratio between the low-speed lanes and the serial line.
  typedef enum logic [1:0] {
    MODE_1TO1,
    MODE_2TO1,
    MODE_4TO1,
    MODE_RSVD
  } mode_t;

  // Source presented on the loss-of-signal pin.
  typedef enum logic [1:0] {
    SEL_LOS,
    SEL_RX_DATA,
    SEL_WAIT_RESET,
    SEL_IRQ
  } sel_t;

  // Channel condition as seen by the data path.
  typedef enum logic [1:0] {
    CH_RUN,
    CH_DOWN,
    CH_WAIT_RESET
  } chan_state_t;

endpackage

// *** rtl/lane_gate.sv ***
// Masks the low-speed lanes that the serialization mode leaves unused.
`timescale 1ns/1ps
module lane_gate #(
  parameter int LANES = 4
) (
  input wire pinctl_pkg::mode_t mode_in,
  input wire logic [LANES-1:0] lanes_in,
  output logic [LANES-1:0] lanes_out,
  output logic [1:0] last_out
);

  // ************************************************************
  // Lane count per mode
  // ************************************************************

  // The lane index is two bits wide, so only four lanes can be served.
  if (LANES != 4) begin : g_bad_lanes
    $error("lane_gate serves exactly four lanes");
  end

  // Reserved mode falls back to lane 0 only, the safest reading.
  always_comb begin
    case (mode_in)
      pinctl_pkg::MODE_2TO1: last_out = 2'h1;
      pinctl_pkg::MODE_4TO1: last_out = 2'h3;
      default: last_out = 2'h0;
    endcase
  end

  // Each lane passes only while its index lies inside the used range.
  for (genvar i = 0; i < LANES; i++) begin : g_lane
    assign lanes_out[i] = lanes_in[i] & (2'(i) <= last_out);
  end

endmodule

// *** rtl/los_detect.sv ***
// Loss-of-signal detector with hysteresis on the measured receive swing.
`timescale 1ns/1ps
`include "pinctl_defines.svh"
module los_detect (
  input wire logic clock_in,
  input wire logic resetn_in,
  input wire logic [`SWING_W-1:0] swing_in,
  input wire logic enable_in,
  output logic los_out
);

  typedef struct packed {
    logic los;
  } los_state_t;

  los_state_t st;
  los_state_t next_st;

  // ************************************************************
  // Hysteresis
  // ************************************************************

  // Between the two thresholds the flag keeps its value, so a swing that
  // hovers near one level cannot make the pin chatter.
  always_comb begin
    next_st = st;
    if (!enable_in) begin
      next_st.los = 1'b0;
    end else if (swing_in < `LOS_ASSERT_MVPP) begin
      next_st.los = 1'b1;
    end else if (swing_in > `LOS_RELEASE_MVPP) begin
      next_st.los = 1'b0;
    end
  end

  // Register the flag; cleared while reset is held.
  always_ff @(posedge clock_in or negedge resetn_in) begin
    if (!resetn_in) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign los_out = st.los;

endmodule

// *** rtl/channel_pin_state_control.sv ***
// Pin-state control of one transceiver channel: power-down, lanes, loss-of-signal pin, APB regs.
//
// What this block does
// - Power-down pin low idles the channel.
// - Reset drives serial transmit to differential zero.
// - Transmit uses lane 0, lanes 0-1 or lanes 0-3.
// - Receive lanes limited by mode; zero in reset.
// - Loss flag: 1 lost, only when enabled.
// - Assert below 75, release above 150 mVpp.
// - Loss pin can show other live functions.
// - Reset drives loss pin low.
// - Powered-down channel leaves loss pin floating.
`timescale 1ns/1ps
`include "pinctl_defines.svh"
module channel_pin_state_control (
  input wire logic clock_in,
  input wire logic resetn_in,
  input wire logic chan_b_powerdown_n_in,
  input wire logic chan_b_serial_rx_pos_in,
  input wire logic chan_b_serial_rx_neg_in,
  input wire logic [`SWING_W-1:0] rx_swing_mvpp_in,
  input wire logic [3:0] chan_b_lowspeed_in_lanes_in,
  output logic chan_b_serial_tx_pos_out,
  output logic chan_b_serial_tx_neg_out,
  output logic [3:0] chan_b_lowspeed_out_lanes_pos_out,
  output logic [3:0] chan_b_lowspeed_out_lanes_neg_out,
  output logic chan_b_signal_loss_flag_out,
  output logic chan_b_signal_loss_flag_oe_out,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [7:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  output logic [31:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  output logic irq_out
);

  // ************************************************************
  // State
  // ************************************************************

  typedef struct packed {
    logic pd_meta;
    logic pd_sync;
    logic [1:0] rx_meta;
    logic [1:0] rx_sync;
    logic [3:0] in_meta;
    logic [3:0] in_sync;
    logic [`SWING_W-1:0] sw_meta;
    logic [`SWING_W-1:0] sw_sync;
    pinctl_pkg::chan_state_t chan;
    logic [1:0] idx;
    logic [3:0] rx_shift;
    pinctl_pkg::mode_t mode;
    pinctl_pkg::sel_t sel;
    logic los_en;
    logic reg_pd;
    logic los_prev;
    logic [`EVT_W-1:0] status;
    logic [`EVT_W-1:0] mask;
    logic tx_pos;
    logic tx_neg;
    logic [3:0] out_pos;
    logic [3:0] out_neg;
    logic flag;
    logic flag_oe;
    logic pready;
    logic [31:0] prdata;
    logic pslverr;
    logic irq;
  } top_state_t;

  top_state_t st;
  top_state_t next_st;

  logic los;
  logic pd_now;
  logic rx_bit;
  logic acc;
  logic wr;
  logic dp_reset_wr;
  logic [1:0] last_idx;
  logic [1:0] eidx;
  logic [3:0] in_used;
  logic [3:0] rx_word;
  logic [3:0] rx_used;
  logic [`EVT_W-1:0] events;
  logic [`EVT_W-1:0] w1c;
  logic [31:0] rd_data;
  logic rd_hit;

  // ************************************************************
  // Helpers
  // ************************************************************

  // Only lanes that the mode allows reach the serializer.
  lane_gate #(.LANES(4)) u_in_gate (
    .mode_in(st.mode),
    .lanes_in(st.in_sync),
    .lanes_out(in_used),
    .last_out(last_idx)
  );

  // Received lanes beyond the mode's range stay idle.
  lane_gate #(.LANES(4)) u_out_gate (
    .mode_in(st.mode),
    .lanes_in(rx_word),
    .lanes_out(rx_used),
    .last_out()
  );

  // The swing word is a slowly moving analog reading; a torn sample lasts
  // one cycle and the hysteresis band absorbs it.
  los_detect u_los (
    .clock_in(clock_in),
    .resetn_in(resetn_in),
    .swing_in(st.sw_sync),
    .enable_in(st.los_en),
    .los_out(los)
  );

  // ************************************************************
  // Decode
  // ************************************************************

  // Either the pin or the control bit powers the channel down.
  assign pd_now = !st.pd_sync || st.reg_pd;
  assign rx_bit = st.rx_sync[1] & ~st.rx_sync[0];
  assign acc = psel_in && penable_in && st.pready;
  assign wr = acc && pwrite_in;
  assign dp_reset_wr = wr && (paddr_in == `CTRL_OFFSET) && pwdata_in[`CTRL_DP_RESET_BIT];
  assign w1c = (wr && (paddr_in == `STATUS_OFFSET)) ? pwdata_in[`EVT_W-1:0] : '0;

  // A lane index left beyond range by a mode change falls back to lane 0.
  assign eidx = (st.idx > last_idx) ? 2'h0 : st.idx;

  // Current received bit is merged into its slot to complete the word.
  always_comb begin
    rx_word = st.rx_shift;
    rx_word[eidx] = rx_bit;
  end

  // Events: both loss edges and the release of power-down.
  always_comb begin
    events = '0;
    events[`EVT_LOS_RISE] = los && !st.los_prev;
    events[`EVT_LOS_FALL] = !los && st.los_prev;
    events[`EVT_PD_RELEASE] = (st.chan == pinctl_pkg::CH_DOWN) && !pd_now;
  end

  // Read mux; an unmapped offset answers zero with an error.
  always_comb begin
    rd_data = '0;
    rd_hit = 1'b1;
    case (paddr_in)
      `CTRL_OFFSET: begin
        rd_data[`CTRL_MODE_LSB +: 2] = st.mode;
        rd_data[`CTRL_SEL_LSB +: 2] = st.sel;
        rd_data[`CTRL_LOS_EN_BIT] = st.los_en;
        rd_data[`CTRL_POWERDOWN_BIT] = st.reg_pd;
      end
      `STATUS_OFFSET: rd_data[`EVT_W-1:0] = st.status;
      `MASK_OFFSET: rd_data[`EVT_W-1:0] = st.mask;
      `STATE_OFFSET: begin
        rd_data[`STATE_LOS_BIT] = los;
        rd_data[`STATE_PD_BIT] = pd_now;
        rd_data[`STATE_WAIT_BIT] = st.chan == pinctl_pkg::CH_WAIT_RESET;
        rd_data[`STATE_MODE_LSB +: 2] = st.mode;
      end
      default: rd_hit = 1'b0;
    endcase
  end

  // ************************************************************
  // Next state
  // ************************************************************

  always_comb begin
    next_st = st;
    // Two-stage synchronisers for every pin input.
    next_st.pd_meta = chan_b_powerdown_n_in;
    next_st.pd_sync = st.pd_meta;
    next_st.rx_meta = {chan_b_serial_rx_pos_in, chan_b_serial_rx_neg_in};
    next_st.rx_sync = st.rx_meta;
    next_st.in_meta = chan_b_lowspeed_in_lanes_in;
    next_st.in_sync = st.in_meta;
    next_st.sw_meta = rx_swing_mvpp_in;
    next_st.sw_sync = st.sw_meta;
    next_st.los_prev = los;

    // APB: answer in the access cycle, data prepared during setup.
    next_st.pready = psel_in && !penable_in;
    if (psel_in && !penable_in) begin
      next_st.prdata = rd_data;
      next_st.pslverr = !rd_hit;
    end
    if (wr && (paddr_in == `CTRL_OFFSET)) begin
      next_st.mode = pinctl_pkg::mode_t'(pwdata_in[`CTRL_MODE_LSB +: 2]);
      next_st.sel = pinctl_pkg::sel_t'(pwdata_in[`CTRL_SEL_LSB +: 2]);
      next_st.los_en = pwdata_in[`CTRL_LOS_EN_BIT];
      next_st.reg_pd = pwdata_in[`CTRL_POWERDOWN_BIT];
    end
    if (wr && (paddr_in == `MASK_OFFSET)) begin
      next_st.mask = pwdata_in[`EVT_W-1:0];
    end

    // Sticky status: a new event wins over a clear in the same cycle.
    next_st.status = (st.status & ~w1c) | events;
    next_st.irq = |(next_st.status & st.mask);

    // Channel condition. After power-down the data path stays idle until
    // software issues the data-path reset, so no stale lane word escapes.
    case (st.chan)
      pinctl_pkg::CH_RUN: begin
        if (pd_now) begin
          next_st.chan = pinctl_pkg::CH_DOWN;
        end
      end
      pinctl_pkg::CH_DOWN: begin
        if (!pd_now) begin
          next_st.chan = pinctl_pkg::CH_WAIT_RESET;
        end
      end
      pinctl_pkg::CH_WAIT_RESET: begin
        if (pd_now) begin
          next_st.chan = pinctl_pkg::CH_DOWN;
        end else if (dp_reset_wr) begin
          next_st.chan = pinctl_pkg::CH_RUN;
        end
      end
      default: next_st.chan = pinctl_pkg::CH_DOWN;
    endcase

    // Serializer and deserializer step one lane per cycle from lane 0 up.
    if (st.chan == pinctl_pkg::CH_RUN && !pd_now) begin
      next_st.tx_pos = in_used[eidx];
      next_st.tx_neg = !in_used[eidx];
      next_st.rx_shift = rx_word;
      next_st.idx = (eidx == last_idx) ? 2'h0 : eidx + 2'h1;
      if (eidx == last_idx) begin
        next_st.out_pos = rx_used;
        next_st.out_neg = ~rx_used;
      end
    end else begin
      next_st.tx_pos = 1'b0;
      next_st.tx_neg = 1'b1;
      next_st.out_pos = '0;
      next_st.out_neg = '1;
      next_st.idx = 2'h0;
      next_st.rx_shift = '0;
    end

    // Loss pin: floats while powered down, else shows the chosen source.
    next_st.flag_oe = !pd_now;
    case (st.sel)
      pinctl_pkg::SEL_LOS: next_st.flag = los;
      pinctl_pkg::SEL_RX_DATA: next_st.flag = rx_bit;
      pinctl_pkg::SEL_WAIT_RESET: next_st.flag = st.chan == pinctl_pkg::CH_WAIT_RESET;
      default: next_st.flag = st.irq;
    endcase
    if (pd_now) begin
      next_st.flag = 1'b0;
    end
  end

  // ************************************************************
  // Registers
  // ************************************************************

  // Reset holds the serial and lane outputs at differential zero and
  // drives the loss pin low; all come straight from these flops. The
  // power-down synchroniser starts at the released level, so no false
  // power-down and release event follows reset.
  always_ff @(posedge clock_in or negedge resetn_in) begin
    if (!resetn_in) begin
      st <= '0;
      st.pd_meta <= 1'b1;
      st.pd_sync <= 1'b1;
      st.chan <= pinctl_pkg::CH_WAIT_RESET;
      st.mode <= pinctl_pkg::mode_t'(`MODE_RESET);
      st.sel <= pinctl_pkg::sel_t'(`SEL_RESET);
      st.los_en <= `LOS_EN_RESET;
      st.reg_pd <= `REG_PD_RESET;
      st.mask <= `MASK_RESET;
      st.tx_neg <= 1'b1;
      st.out_neg <= 4'hf;
      st.flag_oe <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  assign chan_b_serial_tx_pos_out = st.tx_pos;
  assign chan_b_serial_tx_neg_out = st.tx_neg;
  assign chan_b_lowspeed_out_lanes_pos_out = st.out_pos;
  assign chan_b_lowspeed_out_lanes_neg_out = st.out_neg;
  assign chan_b_signal_loss_flag_out = st.flag;
  assign chan_b_signal_loss_flag_oe_out = st.flag_oe;
  assign prdata_out = st.prdata;
  assign pready_out = st.pready;
  assign pslverr_out = st.pslverr;
  assign irq_out = st.irq;

  // ************************************************************
  // Assertions
  // ************************************************************

  default clocking cb @(posedge clock_in); endclocking
  default disable iff (!resetn_in);

  a_pd_idles_lanes: assert property (pd_now |=> !chan_b_serial_tx_pos_out
    && chan_b_lowspeed_out_lanes_pos_out == 4'h0)
    else $error("powered-down channel drove data");
  a_wait_for_reset: assert property (st.chan == pinctl_pkg::CH_WAIT_RESET
    && !dp_reset_wr |=> st.chan != pinctl_pkg::CH_RUN)
    else $error("data path ran without a data-path reset");
  a_reset_tx_zero: assert property ($past(!resetn_in) |-> !chan_b_serial_tx_pos_out
    && chan_b_serial_tx_neg_out)
    else $error("serial transmit not differential zero after reset");
  a_tx_lane_zero: assert property (st.chan == pinctl_pkg::CH_RUN && !pd_now
    && st.mode == pinctl_pkg::MODE_1TO1 |=> chan_b_serial_tx_pos_out == $past(st.in_sync[0]))
    else $error("1:1 mode did not send lane 0");
  a_reset_lanes_zero: assert property ($past(!resetn_in)
    |-> chan_b_lowspeed_out_lanes_pos_out == 4'h0 && chan_b_lowspeed_out_lanes_neg_out == 4'hf)
    else $error("receive lanes not differential zero after reset");
  a_unused_lanes_idle: assert property (st.mode == pinctl_pkg::MODE_2TO1
    && $past(st.mode) == pinctl_pkg::MODE_2TO1 |=> chan_b_lowspeed_out_lanes_pos_out[3:2] == 2'h0)
    else $error("2:1 mode drove an unused lane");
  a_wide_word: assert property (st.chan == pinctl_pkg::CH_RUN && !pd_now
    && st.mode == pinctl_pkg::MODE_4TO1 && eidx == 2'h3
    |=> chan_b_lowspeed_out_lanes_pos_out == $past({rx_bit, st.rx_shift[2:0]}))
    else $error("4:1 word not assembled from lane 0 upward");
  a_los_disabled: assert property (!st.los_en |=> !los)
    else $error("loss flag set while detection disabled");
  a_los_assert: assert property (st.los_en && st.sw_sync < `LOS_ASSERT_MVPP |=> los)
    else $error("loss not flagged below 75 mVpp");
  a_los_hold: assert property (los && st.los_en && st.sw_sync <= `LOS_RELEASE_MVPP |=> los)
    else $error("loss released at or below 150 mVpp");
  a_alt_source: assert property (!pd_now && st.sel == pinctl_pkg::SEL_RX_DATA
    |=> chan_b_signal_loss_flag_out == $past(rx_bit))
    else $error("loss pin does not show selected source");
  a_reset_los_low: assert property ($past(!resetn_in) |-> !chan_b_signal_loss_flag_out
    && chan_b_signal_loss_flag_oe_out)
    else $error("loss pin not driven low after reset");
  a_pd_floats: assert property (pd_now |=> !chan_b_signal_loss_flag_oe_out)
    else $error("loss pin driven while powered down");

  c_pd_release: cover property (st.chan == pinctl_pkg::CH_DOWN ##1
    st.chan == pinctl_pkg::CH_WAIT_RESET ##[1:50] st.chan == pinctl_pkg::CH_RUN);
  c_los_cycle: cover property ($rose(los) ##[1:100] $fell(los));
  c_wide_word: cover property (st.mode == pinctl_pkg::MODE_4TO1 && st.chan == pinctl_pkg::CH_RUN
    && eidx == 2'h3);

endmodule

// *** testbench/host_model.sv ***
// Host model: APB master and driver of the channel power-down pin.
`timescale 1ns/1ps
`include "pinctl_defines.svh"
module host_model (
  input wire logic clock_in,
  output logic psel_out,
  output logic penable_out,
  output logic pwrite_out,
  output logic [7:0] paddr_out,
  output logic [31:0] pwdata_out,
  input wire logic [31:0] prdata_in,
  input wire logic pready_in,
  input wire logic pslverr_in,
  output logic powerdown_n_out
);
  // Bus idle and pin released from time zero, so the channel starts awake.
  initial begin
    psel_out = 1'b0;
    penable_out = 1'b0;
    pwrite_out = 1'b0;
    paddr_out = 8'h00;
    pwdata_out = 32'h0000_0000;
    powerdown_n_out = 1'b1;
  end

  // One APB transfer; it waits for pready as long as it takes, and only the
  // bench's watchdog ends a wait on a dead slave.
  task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q, output logic err);
    begin
      @(posedge clock_in);
      psel_out <= 1'b1;
      penable_out <= 1'b0;
      pwrite_out <= wr;
      paddr_out <= a;
      pwdata_out <= d;
      @(posedge clock_in);
      penable_out <= 1'b1;
      do begin
        @(posedge clock_in);
      end while (pready_in !== 1'b1);
      q = prdata_in;
      err = pslverr_in;
      psel_out <= 1'b0;
      penable_out <= 1'b0;
      // Released lines toggle so that no stale value is mistaken for a live one.
      paddr_out <= ~a;
      pwdata_out <= ~d;
    end
  endtask

  // Drives the power-down pin just after a clock edge.
  task automatic set_pin(input logic v);
    @(posedge clock_in);
    powerdown_n_out <= v;
  endtask

  // Release the pin, poll state up to 16 times until the channel reports it waits, then reset the data path.
  task automatic wake(input logic [31:0] ctrl, output logic seen);
    logic [31:0] q;
    logic e;
    int n;
    begin
      seen = 1'b0;
      n = 0;
      powerdown_n_out <= 1'b1;
      while (!seen && n < 16) begin
        xfer(1'b0, `STATE_OFFSET, 32'h0000_0000, q, e);
        seen = (q[`STATE_WAIT_BIT] === 1'b1);
        n++;
      end
      xfer(1'b1, `CTRL_OFFSET, ctrl | 32'h0000_0100, q, e);
    end
  endtask
endmodule

// *** testbench/tb.sv ***
// Self-checking bench for the channel pin-state block.
`timescale 1ns/1ps
`include "pinctl_defines.svh"
module tb;
  logic clock_in;
  logic resetn_in;
  logic rx_pos;
  logic rx_neg;
  logic [8:0] swing;
  logic [3:0] lanes_in;
  logic tx_pos;
  logic tx_neg;
  logic [3:0] out_pos;
  logic [3:0] out_neg;
  logic flag;
  logic flag_oe;
  logic psel;
  logic penable;
  logic pwrite;
  logic [7:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic irq;
  logic pd_n;
  logic [31:0] rd;
  logic err;
  logic seen;
  int ones;
  int fails = 0;
  int compares = 0;

  typedef struct {
    logic [31:0] ctrl;
    logic [3:0] lanes;
    logic [8:0] swing;
    int ones;
    logic [3:0] out;
    logic flag;
  } row_t;

  // ************************************************************
  // Ordinary cases: mode, lane pattern and swing beside expected pins
  // ************************************************************
  // Swings walk the hysteresis band so the rows whose swing lies inside the band depend on the one before.
  row_t rows [8] = '{
    '{32'h0000_0110, 4'he, 9'h0c8, 0, 4'h1, 1'b0},
    '{32'h0000_0111, 4'hd, 9'h04b, 4, 4'h3, 1'b0},
    '{32'h0000_0112, 4'h8, 9'h04a, 2, 4'hf, 1'b1},
    '{32'h0000_0113, 4'h1, 9'h096, 8, 4'h1, 1'b1},
    '{32'h0000_0110, 4'h1, 9'h097, 8, 4'h1, 1'b0},
    '{32'h0000_0110, 4'h0, 9'h064, 0, 4'h1, 1'b0},
    '{32'h0000_0100, 4'h0, 9'h00a, 0, 4'h1, 1'b0},
    '{32'h0000_0110, 4'h0, 9'h00a, 0, 4'h1, 1'b1}
  };

  // 200 MHz clock.
  initial begin
    clock_in = 1'b0;
    forever #2.5 clock_in = ~clock_in;
  end

  channel_pin_state_control dut (
    .clock_in(clock_in),
    .resetn_in(resetn_in),
    .chan_b_powerdown_n_in(pd_n),
    .chan_b_serial_rx_pos_in(rx_pos),
    .chan_b_serial_rx_neg_in(rx_neg),
    .rx_swing_mvpp_in(swing),
    .chan_b_lowspeed_in_lanes_in(lanes_in),
    .chan_b_serial_tx_pos_out(tx_pos),
    .chan_b_serial_tx_neg_out(tx_neg),
    .chan_b_lowspeed_out_lanes_pos_out(out_pos),
    .chan_b_lowspeed_out_lanes_neg_out(out_neg),
    .chan_b_signal_loss_flag_out(flag),
    .chan_b_signal_loss_flag_oe_out(flag_oe),
    .psel_in(psel),
    .penable_in(penable),
    .pwrite_in(pwrite),
    .paddr_in(paddr),
    .pwdata_in(pwdata),
    .prdata_out(prdata),
    .pready_out(pready),
    .pslverr_out(pslverr),
    .irq_out(irq)
  );

  host_model host (
    .clock_in(clock_in),
    .psel_out(psel),
    .penable_out(penable),
    .pwrite_out(pwrite),
    .paddr_out(paddr),
    .pwdata_out(pwdata),
    .prdata_in(prdata),
    .pready_in(pready),
    .pslverr_in(pslverr),
    .powerdown_n_out(pd_n)
  );

  task automatic check(input logic ok, input string what);
    compares++;
    if (ok !== 1'b1) begin
      fails++;
      $display("mismatch at %0t: %s", $time, what);
    end
  endtask

  // Lets levels pass the input synchronisers and the output flops.
  task automatic settle;
    repeat (12) @(posedge clock_in);
  endtask

  task automatic reset_look;
    check(tx_pos === 1'b0 && tx_neg === 1'b1 && out_pos === 4'h0 && out_neg === 4'hf
          && flag === 1'b0 && flag_oe === 1'b1 && irq === 1'b0, "pins in reset");
  endtask

  task automatic wrap_up;
    if (fails == 0 && compares > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // A run takes a few hundred cycles; this cuts off a hang well beyond that.
  initial begin
    #200000;
    fails++;
    wrap_up();
  end

  // ************************************************************
  // Main sequence
  // ************************************************************
  initial begin
    resetn_in = 1'b0;
    rx_pos = 1'b1;
    rx_neg = 1'b0;
    swing = 9'h0c8;
    lanes_in = 4'h0;
    repeat (20) @(posedge clock_in);
    reset_look();
    resetn_in <= 1'b1;
    for (int i = 0; i < 8; i++) begin
      host.xfer(1'b1, `CTRL_OFFSET, rows[i].ctrl, rd, err);
      lanes_in <= rows[i].lanes;
      swing <= rows[i].swing;
      settle();
      ones = 0;
      repeat (8) begin
        @(posedge clock_in);
        if (tx_pos === 1'b1 && tx_neg === 1'b0) ones++;
      end
      check(ones == rows[i].ones, "serial tx lane use");
      check(out_pos === rows[i].out && out_neg === ~rows[i].out, "rx lanes");
      check(flag === rows[i].flag && flag_oe === 1'b1, "loss flag");
    end
    // Loss rise unmasked, then cleared, then a masked loss fall.
    host.xfer(1'b1, `MASK_OFFSET, 32'h0000_0001, rd, err);
    repeat (4) @(posedge clock_in);
    check(irq === 1'b1, "irq on loss");
    host.xfer(1'b1, `STATUS_OFFSET, 32'h0000_0007, rd, err);
    repeat (4) @(posedge clock_in);
    check(irq === 1'b0, "irq after clear");
    swing <= 9'h0c8;
    settle();
    host.xfer(1'b0, `STATUS_OFFSET, 32'h0000_0000, rd, err);
    check(rd[2:0] === 3'h2 && irq === 1'b0, "masked loss fall");
    host.xfer(1'b0, `STATE_OFFSET, 32'h0000_0000, rd, err);
    check(rd[2:0] === 3'h0 && err === 1'b0, "state running");
    host.xfer(1'b0, 8'h10, 32'h0000_0000, rd, err);
    check(err === 1'b1 && rd === 32'h0000_0000, "unmapped read");
    // Live receive bit shown on the loss pin.
    host.xfer(1'b1, `CTRL_OFFSET, 32'h0000_0114, rd, err);
    for (int b = 0; b < 2; b++) begin
      rx_pos <= b[0];
      rx_neg <= ~b[0];
      settle();
      check(flag === b[0], "live rx on loss pin");
    end
    // Pin power-down, release and data-path reset.
    host.xfer(1'b1, `CTRL_OFFSET, 32'h0000_0110, rd, err);
    lanes_in <= 4'h1;
    host.set_pin(1'b0);
    settle();
    check(flag_oe === 1'b0 && tx_pos === 1'b0 && tx_neg === 1'b1 && out_neg === 4'hf,
          "pin power-down");
    host.xfer(1'b0, `STATE_OFFSET, 32'h0000_0000, rd, err);
    check(rd[1] === 1'b1, "state down");
    host.wake(32'h0000_0010, seen);
    host.xfer(1'b0, `STATUS_OFFSET, 32'h0000_0000, rd, err);
    check(seen === 1'b1 && rd[2] === 1'b1, "release event");
    settle();
    check(tx_pos === 1'b1 && flag_oe === 1'b1, "data resumes");
    // Register power-down.
    host.xfer(1'b1, `CTRL_OFFSET, 32'h0000_8110, rd, err);
    settle();
    check(flag_oe === 1'b0 && tx_pos === 1'b0, "register power-down");
    host.xfer(1'b1, `CTRL_OFFSET, 32'h0000_0010, rd, err);
    host.xfer(1'b1, `CTRL_OFFSET, 32'h0000_0110, rd, err);
    settle();
    check(flag_oe === 1'b1 && tx_pos === 1'b1, "register wake");
    // Reset in mid-run while the loss flag is high.
    swing <= 9'h00a;
    settle();
    resetn_in <= 1'b0;
    @(posedge clock_in);
    #1;
    reset_look();
    // Release again: the channel must wait for a data-path reset, with no false release event.
    @(posedge clock_in);
    resetn_in <= 1'b1;
    host.xfer(1'b0, `STATE_OFFSET, 32'h0000_0000, rd, err);
    check(rd[2:1] === 2'h2, "state after second reset");
    host.xfer(1'b0, `STATUS_OFFSET, 32'h0000_0000, rd, err);
    check(rd[2] === 1'b0, "no release event after reset");
    check(tx_pos === 1'b0 && tx_neg === 1'b1 && flag_oe === 1'b1,
          "idle until data-path reset");
    wrap_up();
  end
endmodule
